// ===== rtl/pwm_pair_map.vh
// Functional notes
// - run set: status rises on first count clock, counting starts on second.
// - counter equal to duty buffer drives output flag low next count clock.
// - repeat: period match sets flag, counter returns to zero, counting continues.
// - period match copies duty and period settings into their buffers.
// - one-shot: writing run again after the stop resumes counting.
// - run cleared: one more count clock is counted, then halt and status clears.
// - restart after stop continues from the held counter value, no reset.
// - any write to a counter byte zeroes the counter and sets the flag.
// - while stopped, duty and period writes pass straight into the buffers.
// - count clock from control zero and six; interrupt point, polarity from zero.
// - coupled: second output polarity comes from its own control zero.
// - external start, stop, clear by mode bits, trigger bits and pin select.
// - period is period setting plus one; first half is duty plus one.
// - first interrupt may slip one count clock; later ones are periodic.
// - interrupt can still fire in the final counted clock after run clears.
// - coupled: first counter equal to second duty buffer drives second flag low.
// - coupled: first counter equal to second period buffer sets second flag.
// - coupled: second delays are its duty plus one and period plus one clocks.
// - clear-ignore set: external clears are dropped in the first half cycle.
// - coupled one-shot: period match zeroes counter, stops, clears run bit.
`ifndef PWM_PAIR_MAP_VH
`define PWM_PAIR_MAP_VH

// write target codes on WR_REG
`define REG_CNT_L 3'h0
`define REG_CNT_H 3'h1
`define REG_DUTY_L 3'h2
`define REG_DUTY_H 3'h3
`define REG_PER_L 3'h4
`define REG_PER_H 3'h5
`define REG_RUN 3'h6

// start mode field
`define SMODE_SOFT 2'h0
`define SMODE_LEVEL 2'h1
`define SMODE_EDGE 2'h2
`define SMODE_CLEAR 2'h3

// trigger field
`define TGE_HIGH_RISE 2'h1
`define TGE_LOW_FALL 2'h2

// interrupt point field
`define ISEL_PERIOD 2'h0
`define ISEL_DUTY 2'h1

// count clock divider
`define PRE_W 7
`define PRE_EXT_SHIFT 3'h4

// reset values
`define CNT_RST 16'h0000
`define DUTY_RST 16'h0000
`define PER_RST 16'hffff
`define FLAG_RST 1'b1

`endif

// ===== rtl/paired_pwm_channel_pair.v
`timescale 1ns/100ps
`include "pwm_pair_map.vh"

module paired_pwm_channel_pair (
  input wire MCLK,
  input wire RST,
  input wire WR_EN,
  input wire WR_CH,
  input wire [2:0] WR_REG,
  input wire [7:0] WR_DATA,
  input wire [3:0] CLK_SEL,
  input wire [1:0] CLK_SEL_EXT,
  input wire [3:0] INT_SEL,
  input wire [1:0] POLARITY,
  input wire [1:0] SHOT_MODE,
  input wire PAIR_MODE,
  input wire [3:0] START_MODE,
  input wire [3:0] TRIG_EDGE,
  input wire [1:0] TRIG_SEL,
  input wire [1:0] CLEAR_IGNORE,
  input wire EXT_IN0,
  input wire EXT_IN1,
  output wire [31:0] COUNT,
  output wire [31:0] DUTY_BUF,
  output wire [31:0] PERIOD_BUF,
  output wire [1:0] RUN,
  output wire [1:0] STATUS,
  output wire [1:0] FLAG,
  output wire [1:0] PWM_OUT,
  output wire [1:0] CH_INT
);

  // ****************************************
  // count clock tick
  // ****************************************
  function tick_fn;
    input [`PRE_W-1:0] pre;
    input [1:0] sel;
    input ext;
    reg [2:0] n;
    reg [7:0] m;
    begin
      n = {1'b0, sel} + (ext ? `PRE_EXT_SHIFT : 3'h0);
      m = (8'h01 << n) - 8'h01;
      tick_fn = &(pre | ~m[`PRE_W-1:0]);
    end
  endfunction

  reg [`PRE_W-1:0] pre_r;
  reg ext0_a_r;
  reg ext0_s_r;
  reg ext1_a_r;
  reg ext1_s_r;

  always @(posedge MCLK or posedge RST) begin
    if (RST) begin
      pre_r <= {`PRE_W{1'b0}};
      ext0_a_r <= 1'b0;
      ext0_s_r <= 1'b0;
      ext1_a_r <= 1'b0;
      ext1_s_r <= 1'b0;
    end else begin
      pre_r <= pre_r + {{(`PRE_W-1){1'b0}}, 1'b1};
      ext0_a_r <= EXT_IN0;
      ext0_s_r <= ext0_a_r;
      ext1_a_r <= EXT_IN1;
      ext1_s_r <= ext1_a_r;
    end
  end

  wire [1:0] step_all;
  wire [1:0] pm_all;
  wire [1:0] stat_all;
  wire [31:0] cnt_all;

  assign COUNT = cnt_all;
  assign STATUS = stat_all;

  // ****************************************
  // channels
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : ch
      reg [15:0] cnt_r;
      reg [15:0] dset_r;
      reg [15:0] pset_r;
      reg [15:0] dbuf_r;
      reg [15:0] pbuf_r;
      reg run_r;
      reg stat_r;
      reg flag_r;
      reg out_r;
      reg int_r;
      reg pin_d_r;

      wire slave = PAIR_MODE && (g == 1);
      wire wr = WR_EN && (WR_CH == g);
      wire wr_cnt = wr && ((WR_REG == `REG_CNT_L) || (WR_REG == `REG_CNT_H));
      wire wr_run = wr && (WR_REG == `REG_RUN);
      wire active = slave ? stat_all[0] : stat_r;
      wire tick = tick_fn(pre_r, CLK_SEL[2*g+1:2*g], CLK_SEL_EXT[g]);
      wire [1:0] smode = START_MODE[2*g+1:2*g];
      wire [1:0] tge = TRIG_EDGE[2*g+1:2*g];
      wire [1:0] isel = INT_SEL[2*g+1:2*g];
      wire shot = SHOT_MODE[g];

      wire pin = TRIG_SEL[g] ? ext1_s_r : ext0_s_r;
      wire rise = pin && !pin_d_r;
      wire fall = !pin && pin_d_r;
      wire tge_ok = (tge == `TGE_HIGH_RISE) || (tge == `TGE_LOW_FALL);
      wire act_lvl = (tge == `TGE_HIGH_RISE) ? pin : !pin;
      wire lvl_mode = (smode == `SMODE_LEVEL) && tge_ok && !slave;
      wire edg_mode = (smode == `SMODE_EDGE) && !slave;
      wire start_edge = (tge == `TGE_HIGH_RISE) ? rise : fall;
      wire stop_edge = (tge == `TGE_HIGH_RISE) ? fall : rise;
      wire ext_start = (lvl_mode && act_lvl && !run_r) || (edg_mode && tge_ok && start_edge);
      wire ext_stop = (lvl_mode && !act_lvl && (run_r || stat_r)) ||
                      (edg_mode && tge_ok && stop_edge);
      wire clr_req = (smode == `SMODE_CLEAR) && !slave &&
                     ((tge[0] && fall) || (tge[1] && rise));
      wire clr_ok = clr_req && !(CLEAR_IGNORE[g] && stat_r && flag_r);

      // coupled second channel watches first counter
      wire [15:0] src = slave ? cnt_all[15:0] : cnt_r;
      wire adv = slave ? step_all[0] : (tick && stat_r);
      wire dm = adv && (src == dbuf_r);
      wire pm = adv && (src == pbuf_r);
      wire reload = slave ? pm_all[0] : pm;

      assign step_all[g] = tick && stat_r && !slave;
      assign pm_all[g] = pm && !slave;
      assign stat_all[g] = stat_r;
      assign cnt_all[16*g+15:16*g] = cnt_r;
      assign DUTY_BUF[16*g+15:16*g] = dbuf_r;
      assign PERIOD_BUF[16*g+15:16*g] = pbuf_r;
      assign RUN[g] = run_r;
      assign FLAG[g] = flag_r;
      assign PWM_OUT[g] = out_r;
      assign CH_INT[g] = int_r;

      always @(posedge MCLK or posedge RST) begin
        if (RST) begin
          cnt_r <= `CNT_RST;
          dset_r <= `DUTY_RST;
          pset_r <= `PER_RST;
          dbuf_r <= `DUTY_RST;
          pbuf_r <= `PER_RST;
          run_r <= 1'b0;
          stat_r <= 1'b0;
          flag_r <= `FLAG_RST;
          out_r <= 1'b0;
          int_r <= 1'b0;
          pin_d_r <= 1'b0;
        end else begin
          pin_d_r <= pin;
          out_r <= flag_r ^ POLARITY[g];
          if (isel == `ISEL_PERIOD) begin
            int_r <= pm;
          end else if (isel == `ISEL_DUTY) begin
            int_r <= dm;
          end else begin
            int_r <= pm || dm;
          end

          if (wr && (WR_REG == `REG_DUTY_L)) begin
            dset_r[7:0] <= WR_DATA;
          end
          if (wr && (WR_REG == `REG_DUTY_H)) begin
            dset_r[15:8] <= WR_DATA;
          end
          if (wr && (WR_REG == `REG_PER_L)) begin
            pset_r[7:0] <= WR_DATA;
          end
          if (wr && (WR_REG == `REG_PER_H)) begin
            pset_r[15:8] <= WR_DATA;
          end

          if (reload) begin
            dbuf_r <= dset_r;
            pbuf_r <= pset_r;
          end
          if (!active && wr && (WR_REG == `REG_DUTY_L)) begin
            dbuf_r[7:0] <= WR_DATA;
          end
          if (!active && wr && (WR_REG == `REG_DUTY_H)) begin
            dbuf_r[15:8] <= WR_DATA;
          end
          if (!active && wr && (WR_REG == `REG_PER_L)) begin
            pbuf_r[7:0] <= WR_DATA;
          end
          if (!active && wr && (WR_REG == `REG_PER_H)) begin
            pbuf_r[15:8] <= WR_DATA;
          end

          // status follows run on count clock
          // start waits for a count clock
          if (tick && !slave) begin
            if (!stat_r) begin
              if (run_r) begin
                stat_r <= 1'b1;
              end
            end else if (!run_r) begin
              stat_r <= 1'b0;
            end
          end

          // counting with period and duty compare
          if (adv) begin
            if (pm) begin
              flag_r <= 1'b1;
              if (!slave) begin
                cnt_r <= 16'h0000;
              end
            end else begin
              if (!slave) begin
                cnt_r <= cnt_r + 16'h0001;
              end
              if (dm) begin
                flag_r <= 1'b0;
              end
            end
          end

          if (pm && shot && !slave) begin
            run_r <= 1'b0;
            stat_r <= 1'b0;
          end

          if (wr_cnt || clr_ok || ext_stop) begin
            cnt_r <= 16'h0000;
            flag_r <= 1'b1;
          end
          if (ext_stop) begin
            run_r <= 1'b0;
            stat_r <= 1'b0;
          end

          // software run write, wins over hardware clear
          if (wr_run && !edg_mode && !slave) begin
            run_r <= WR_DATA[0];
          end
          if (ext_start) begin
            run_r <= 1'b1;
          end
        end
      end
    end
  endgenerate

endmodule

// ===== tb/pwm_pair_checker.sv
`timescale 1ns/100ps
`include "pwm_pair_map.vh"
module pwm_pair_checker (
  input wire MCLK,
  input wire RST,
  input wire WR_EN,
  input wire WR_CH,
  input wire [2:0] WR_REG,
  input wire [7:0] WR_DATA,
  input wire [3:0] CLK_SEL,
  input wire [1:0] CLK_SEL_EXT,
  input wire [3:0] INT_SEL,
  input wire [1:0] POLARITY,
  input wire [1:0] SHOT_MODE,
  input wire PAIR_MODE,
  input wire [3:0] START_MODE,
  input wire [31:0] COUNT,
  input wire [31:0] DUTY_BUF,
  input wire [31:0] PERIOD_BUF,
  input wire [1:0] RUN,
  input wire [1:0] STATUS,
  input wire [1:0] FLAG,
  input wire [1:0] PWM_OUT,
  input wire [1:0] CH_INT
);
  // ********
  // channel zero checks, output level on both channels
  // ********
  default clocking @(posedge MCLK); endclocking
  default disable iff (RST);
  // tick every cycle, software start, no write taken
  wire f = CLK_SEL[1:0] == 2'h0 && !CLK_SEL_EXT[0] && START_MODE[1:0] == 2'h0 && !WR_EN;
  wire [15:0] c = COUNT[15:0];
  wire pm = STATUS[0] && c == PERIOD_BUF[15:0];
  a_run_status: assert property (f && $rose(RUN[0]) |=> STATUS[0])
    else $error("status not set after run");
  a_count_step: assert property (f && STATUS[0] && !pm |=> c == $past(c) + 16'h1)
    else $error("count did not step");
  a_period_wrap: assert property (f && pm |=> c == 16'h0 && FLAG[0])
    else $error("period wrap wrong");
  a_duty_low: assert property (f && STATUS[0] && !pm && c == DUTY_BUF[15:0] |=> !FLAG[0])
    else $error("flag not low after duty match");
  a_stop_once: assert property (f && STATUS[0] && !RUN[0] |=> !STATUS[0])
    else $error("status not cleared after stop");
  a_hold_count: assert property (f && !STATUS[0] |=> $stable(c))
    else $error("count moved while stopped");
  a_shot_stop: assert property (f && SHOT_MODE[0] && pm |=> !RUN[0] && !STATUS[0])
    else $error("one-shot did not stop");
  a_int_period: assert property (f && INT_SEL[1:0] == 2'h0 && pm |=> CH_INT[0])
    else $error("period interrupt missing");
  a_out_level: assert property (1'b1 |=> PWM_OUT == ($past(FLAG) ^ $past(POLARITY)))
    else $error("output polarity wrong");
  a_direct_duty: assert property (WR_EN && !WR_CH && WR_REG == `REG_DUTY_L && !STATUS[0]
    && !PAIR_MODE |=> DUTY_BUF[7:0] == $past(WR_DATA))
    else $error("stopped duty write not in buffer");
endmodule
bind paired_pwm_channel_pair pwm_pair_checker u_chk (.*);

// ===== tb/ext_pin_model.sv
`timescale 1ns/100ps
module ext_pin_model (
  input wire MCLK,
  input wire want,
  output reg EXT_IN0,
  output reg EXT_IN1
);
  // ********
  // trigger pins
  // ********
  initial begin
    EXT_IN0 = 1'b0;
    EXT_IN1 = 1'b1;
  end
  always @(posedge MCLK) begin
    EXT_IN0 <= #5 want;
    EXT_IN1 <= #5 ~want;
  end
endmodule

// ===== tb/paired_pwm_channel_pair_tb.sv
`timescale 1ns/100ps
`include "pwm_pair_map.vh"
module paired_pwm_channel_pair_tb;
  // ********
  // bench
  // ********
  reg MCLK = 1'b0, RST = 1'b1, WR_EN = 1'b0, WR_CH = 1'b0, PAIR_MODE = 1'b0, want = 1'b0;
  reg [2:0] WR_REG = 3'h0;
  reg [7:0] WR_DATA = 8'h0;
  reg [3:0] CLK_SEL = 4'h0, INT_SEL = 4'h0, START_MODE = 4'h0, TRIG_EDGE = 4'h0;
  reg [1:0] CLK_SEL_EXT = 2'h0, TRIG_SEL = 2'h0, CLEAR_IGNORE = 2'h0;
  reg [1:0] POLARITY = 2'h0, SHOT_MODE = 2'h0;
  wire EXT_IN0, EXT_IN1;
  wire [31:0] COUNT, DUTY_BUF, PERIOD_BUF;
  wire [1:0] RUN, STATUS, FLAG, PWM_OUT, CH_INT;
  integer n_fail = 0, n_tests = 0, sd = 50902, mon = 1, i, per, dt;
  integer c, d, p, ds, ps, fl, rn, st, ost, f1, d1, p1;
  paired_pwm_channel_pair DUT (.*);
  ext_pin_model PM (.*);
  initial forever #25 MCLK = ~MCLK;
  task chk(input string nm, input [15:0] e, input [15:0] g);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task wr(input ch, input [2:0] r, input [7:0] v);
    begin
      @(posedge MCLK);
      WR_EN <= 1'b1;
      WR_CH <= ch;
      WR_REG <= r;
      WR_DATA <= v;
      @(posedge MCLK);
      WR_EN <= 1'b0;
    end
  endtask
  task cfg(input ch, input [15:0] dv, input [15:0] pv);
    begin
      wr(ch, `REG_DUTY_L, dv[7:0]);
      wr(ch, `REG_DUTY_H, dv[15:8]);
      wr(ch, `REG_PER_L, pv[7:0]);
      wr(ch, `REG_PER_H, pv[15:8]);
    end
  endtask
  task halt;
    begin
      wr(1'b0, `REG_RUN, 8'h0);
      repeat (20) if (STATUS[0]) @(negedge MCLK);
      @(negedge MCLK);
      chk("halted", 16'h0, STATUS[0]);
      @(posedge MCLK);
    end
  endtask
  // reference model of channel zero and the coupled second flag
  always @(posedge MCLK)
    if (RST) begin
      c = 0;
      fl = 1;
      d = 0;
      p = 16'hffff;
      ds = 0;
      ps = 16'hffff;
      rn = 0;
      st = 0;
      f1 = 1;
    end else begin
      ost = st;
      st = rn;
      if (ost) begin
        if (PAIR_MODE && c == d1)
          f1 = 0;
        if (PAIR_MODE && c == p1)
          f1 = 1;
        if (c == p) begin
          c = 0;
          fl = 1;
          d = ds;
          p = ps;
          if (SHOT_MODE[0]) begin
            rn = 0;
            st = 0;
          end
        end else begin
          if (c == d)
            fl = 0;
          c = c + 1;
        end
      end
      if (WR_EN && !WR_CH) begin
        case (WR_REG)
          `REG_CNT_L, `REG_CNT_H: begin
            c = 0;
            fl = 1;
          end
          `REG_DUTY_L: ds[7:0] = WR_DATA;
          `REG_DUTY_H: ds[15:8] = WR_DATA;
          `REG_PER_L: ps[7:0] = WR_DATA;
          `REG_PER_H: ps[15:8] = WR_DATA;
          default: rn = WR_DATA[0];
        endcase
        if (!ost && WR_REG[2:1] == 2'h1)
          d = ds;
        if (!ost && WR_REG[2:1] == 2'h2)
          p = ps;
      end
    end
  always @(negedge MCLK)
    if (!RST && mon) begin
      chk("count", c, COUNT[15:0]);
      chk("flag", fl, FLAG[0]);
      chk("status", st, STATUS[0]);
      chk("run", rn, RUN[0]);
      chk("duty", d, DUTY_BUF[15:0]);
      chk("period", p, PERIOD_BUF[15:0]);
      chk("flag1", f1, FLAG[1]);
    end
  initial begin
    repeat (20000) @(posedge MCLK);
    n_fail = n_fail + 1;
    results;
  end
  initial begin
    repeat (10) @(posedge MCLK);
    RST <= 1'b0;
    for (i = 0; i < 4; i = i + 1) begin
      per = i ? 2 + {$random(sd)} % 29 : 1;
      dt = {$random(sd)} % per;
      POLARITY <= $random(sd);
      cfg(1'b0, dt, per);
      wr(1'b0, `REG_CNT_H, 8'h0);
      wr(1'b0, `REG_RUN, 8'h1);
      repeat (3 * per + 6) @(posedge MCLK);
      wr(1'b0, `REG_CNT_L, 8'h5a);
      repeat (per + 2) @(posedge MCLK);
      halt;
      repeat (4) @(posedge MCLK);
      wr(1'b0, `REG_RUN, 8'h1);
      repeat (per) @(posedge MCLK);
      halt;
    end
    SHOT_MODE <= 2'h1;
    cfg(1'b0, 16'h2, 16'h6);
    wr(1'b0, `REG_CNT_L, 8'h0);
    repeat (2) begin
      wr(1'b0, `REG_RUN, 8'h1);
      repeat (12) @(posedge MCLK);
    end
    cfg(1'b1, 16'h3, 16'h7);
    d1 = 3;
    p1 = 7;
    cfg(1'b0, 16'h5, 16'hc);
    SHOT_MODE <= 2'h0;
    PAIR_MODE <= 1'b1;
    INT_SEL <= 4'h5;
    wr(1'b0, `REG_RUN, 8'h1);
    repeat (40) @(posedge MCLK);
    SHOT_MODE <= 2'h1;
    repeat (20) @(posedge MCLK);
    mon = 0;
    SHOT_MODE <= 2'h0;
    PAIR_MODE <= 1'b0;
    START_MODE <= 4'h1;
    TRIG_EDGE <= 4'h1;
    want <= 1'b1;
    repeat (8) @(posedge MCLK);
    chk("level start", 16'h1, RUN[0]);
    want <= 1'b0;
    repeat (8) @(posedge MCLK);
    chk("level stop", 16'h0, {14'h0, STATUS[0], RUN[0]});
    chk("level stop count", 16'h0, COUNT[15:0]);
    START_MODE <= 4'h2;
    TRIG_EDGE <= 4'h2;
    want <= 1'b1;
    repeat (8) @(posedge MCLK);
    want <= 1'b0;
    repeat (8) @(posedge MCLK);
    chk("edge start", 16'h1, RUN[0]);
    START_MODE <= 4'h3;
    TRIG_EDGE <= 4'h1;
    want <= 1'b1;
    repeat (8) @(posedge MCLK);
    want <= 1'b0;
    repeat (5) @(posedge MCLK);
    chk("ext clear", 16'h0, COUNT[15:0]);
    results;
  end
endmodule
